// >>> rtl/farc_pkg.sv
package farc_pkg;
   // Widths of the measured voltage and of one three-digit decimal counter.
   localparam int VOLT_W  = 16;
   localparam int COUNT_W = 12;
   localparam int TIMER_W = 24;
   localparam int DEB_W   = 24;
   // The high-voltage lamp and relay come on above this level, in volts.
   localparam logic [VOLT_W-1:0] HV_LAMP_VOLTS = 16'h01f4;
   // Percent scale for the set-point window.
   localparam int PCT_SCALE = 100;
   // Clock rate and the settle time of the external contacts.
   localparam int CLK_HZ      = 20_000_000;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
   // Counter clear value and the top digit of one decade.
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 12'h000;
   localparam logic [3:0]         DIGIT_MAX  = 4'h9;
   // Lock levels that gate front-panel functions.
   localparam logic [1:0] LOCK_VOLT = 2'h1;
   localparam logic [1:0] LOCK_CR   = 2'h2;
   localparam logic [1:0] LOCK_R    = 2'h3;

   typedef enum logic [1:0] {
      FT_PINHOLE = 2'b00,
      FT_METAL   = 2'b01,
      FT_MULTI   = 2'b10,
      FT_GROSS   = 2'b11
   } farc_ftype_t;

   typedef enum logic [1:0] {
      RF_HV_ON    = 2'b00,
      RF_FAULT    = 2'b01,
      RF_BARE     = 2'b10,
      RF_WATCHDOG = 2'b11
   } farc_rfunc_t;

   typedef enum logic [1:0] {
      FR_IDLE    = 2'b00,
      FR_ACTIVE  = 2'b01,
      FR_HOLD    = 2'b10,
      FR_LATCHED = 2'b11
   } farc_rstate_t;

   typedef enum logic {
      WD_LIMIT   = 1'b0,
      WD_PERCENT = 1'b1
   } farc_wdmode_t;
endpackage

// >>> rtl/farc_top.sv
`timescale 1ns/1ns
// Function
// - Any-fault alarm asserts on every detected fault, whatever its type.
// - Each defect makes a fault pulse: lamp, counter and relays follow it.
// - Fault pulse lasts while the defect is in the electrode; counted once.
// - High voltage only while the permit input is tied to ground.
// - Latch mode holds the fault relay until panel, terminal or remote reset.
// - Without voltage removal, high voltage stays on while latched.
// - Non-latch relay is active while the defect is in the electrode.
// - Non-latch active time is extended by the process control duration.
// - With voltage removal in latch mode, high voltage is off while latched.
// - A valid reset from latched clears the fault and restores high voltage.
// - Voltage removal has no effect in non-latch mode.
// - Metal contact lasting the gross time is typed gross bare wire.
// - A short fault without metal contact is typed pinhole.
// - Close pinholes or one long fault without metal is multi-pinhole.
// - Metal contact type only when the electrode touches the conductor.
// - Four fault types: pinhole, metal contact, multi-pinhole, gross bare wire.
// - Watchdog alarms outside absolute limits or a percent band of set point, only while high voltage is on.
// - Four relays, each selectable: high voltage, fault, bare wire, watchdog.
// - Bare wire function follows metal contact or gross bare wire faults.
// - Four lock levels decide which panel functions remain available.
// - High-voltage indicator on whenever the output is above 500 volts.
// - Fault reset clears faults and relays but keeps all counts.
// - Count reset clears the total and every per-type count.
// - Total counter has three decimal digits, one step per fault.
module farc_top
   import farc_pkg::*;
#(
   parameter int DEBOUNCE = farc_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic                          i_clk,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_defect,
   input  wire logic                          i_metal,
   input  wire logic [farc_pkg::TIMER_W-1:0]  i_gross_cycles,
   input  wire logic [farc_pkg::TIMER_W-1:0]  i_long_cycles,
   input  wire logic [farc_pkg::TIMER_W-1:0]  i_spacing_cycles,
   input  wire logic [farc_pkg::TIMER_W-1:0]  i_pcd_cycles,
   input  wire logic                          i_latch_mode,
   input  wire logic                          i_remove_hv,
   input  wire logic                          i_hv_request,
   input  wire logic                          i_hv_permit_input_n,
   input  wire logic                          i_ext_reset_n,
   input  wire logic                          i_panel_reset,
   input  wire logic                          i_remote_reset,
   input  wire logic                          i_count_reset,
   input  wire logic                          i_locked,
   input  wire logic [1:0]                    i_lock_level,
   input  wire logic [farc_pkg::VOLT_W-1:0]   i_volt_meas,
   input  wire logic [farc_pkg::VOLT_W-1:0]   i_volt_setpoint,
   input  wire farc_pkg::farc_wdmode_t        i_wd_mode,
   input  wire logic [farc_pkg::VOLT_W-1:0]   i_watchdog_limit_window_hi,
   input  wire logic [farc_pkg::VOLT_W-1:0]   i_watchdog_limit_window_lo,
   input  wire logic [6:0]                    i_setpoint_percent_window,
   input  wire farc_pkg::farc_rfunc_t [3:0]   i_relay_func,
   output logic                               o_fault_pulse,
   output logic                               o_any_fault,
   output logic                               o_fault_lamp,
   output farc_pkg::farc_ftype_t              o_fault_type,
   output logic                               o_type_valid,
   output logic [farc_pkg::COUNT_W-1:0]       o_total_count,
   output logic [3:0][farc_pkg::COUNT_W-1:0]  o_type_count,
   output logic                               o_hv_on,
   output logic                               o_hv_lamp,
   output logic                               o_wd_alarm,
   output logic [3:0]                         o_relay,
   output logic                               o_cfg_allowed,
   output logic                               o_volt_adj_allowed
);
   import farc_pkg::*;

   // Steps a three-digit decimal count, wrapping from 999 to 000.
   function automatic logic [COUNT_W-1:0] bcd_inc(input logic [COUNT_W-1:0] v);
      logic [COUNT_W-1:0] r;
      logic               carry;
      r     = v;
      carry = 1'b1;
      for (int d = 0; d < 3; d++) begin
         if (carry) begin
            if (v[d*4 +: 4] == DIGIT_MAX) begin
               r[d*4 +: 4] = 4'h0;
            end else begin
               r[d*4 +: 4] = v[d*4 +: 4] + 4'h1;
               carry       = 1'b0;
            end
         end
      end
      return r;
   endfunction

   // Two flops, then a stability counter, for both contact inputs.
   // Index 0 is permit, index 1 is external reset; both are true when closed.
   logic [1:0] pins;
   logic [1:0] sync1;
   logic [1:0] sync2;
   logic [1:0] deb;
   assign pins = {~i_ext_reset_n, ~i_hv_permit_input_n};

   for (genvar g = 0; g < 2; g++) begin : g_deb
      logic [DEB_W-1:0] cnt;
      logic [DEB_W-1:0] next_cnt;
      logic             next_deb;
      // A level must hold the full debounce time before it is taken.
      always_comb begin
         next_cnt = '0;
         next_deb = deb[g];
         if (sync2[g] != deb[g]) begin
            if (cnt >= DEB_W'(DEBOUNCE - 1)) begin
               next_deb = sync2[g];
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
      end
      always_ff @(posedge i_clk) begin
         if (!i_rst_n) begin
            sync1[g] <= 1'b0;
            sync2[g] <= 1'b0;
            deb[g]   <= 1'b0;
            cnt      <= '0;
         end else begin
            sync1[g] <= pins[g];
            sync2[g] <= sync1[g];
            deb[g]   <= next_deb;
            cnt      <= next_cnt;
         end
      end
   end

   logic permit_ok;
   logic ext_reset_d;
   logic reset_req;
   logic count_clear;
   assign permit_ok = deb[0];
   // Only the closing edge of the reset contact counts, so a held switch acts once.
   assign reset_req = (deb[1] & ~ext_reset_d) | i_remote_reset
                    | (i_panel_reset & ~(i_locked & (i_lock_level == LOCK_R)));
   assign count_clear = i_count_reset & ~(i_locked & (i_lock_level >= LOCK_CR));

   // Fault detection and typing; the type is known when the defect leaves.
   logic               defect_d;
   logic               fault_event;
   logic               fault_end;
   logic [TIMER_W-1:0] dur;
   logic [TIMER_W-1:0] gap;
   logic               metal_seen;
   logic               near_prev;
   logic               strobe;
   farc_ftype_t        ftype;
   logic [TIMER_W-1:0] next_dur;
   logic [TIMER_W-1:0] next_gap;
   logic               next_metal_seen;
   logic               next_near_prev;
   logic               next_strobe;
   farc_ftype_t        next_ftype;
   assign fault_event = i_defect & ~defect_d;
   assign fault_end   = ~i_defect & defect_d;

   always_comb begin
      next_dur        = dur;
      next_gap        = gap;
      next_metal_seen = metal_seen;
      next_near_prev  = near_prev;
      next_strobe     = 1'b0;
      next_ftype      = ftype;
      if (fault_event) begin
         next_dur        = TIMER_W'(1);
         next_metal_seen = i_metal;
         next_near_prev  = (gap < i_spacing_cycles) && (gap != '0);
      end else if (i_defect) begin
         next_dur        = (&dur) ? dur : dur + 1'b1;
         next_metal_seen = metal_seen | i_metal;
      end
      if (fault_end) begin
         next_strobe = 1'b1;
         next_gap    = TIMER_W'(1);
         if (metal_seen && dur >= i_gross_cycles) begin
            next_ftype = FT_GROSS;
         end else if (metal_seen) begin
            next_ftype = FT_METAL;
         end else if (near_prev || dur >= i_long_cycles) begin
            next_ftype = FT_MULTI;
         end else begin
            next_ftype = FT_PINHOLE;
         end
      end else if (!i_defect && gap != '0 && !(&gap)) begin
         next_gap = gap + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         defect_d   <= 1'b0;
         dur        <= '0;
         gap        <= '0;
         metal_seen <= 1'b0;
         near_prev  <= 1'b0;
         strobe     <= 1'b0;
         ftype      <= FT_PINHOLE;
      end else begin
         defect_d   <= i_defect;
         dur        <= next_dur;
         gap        <= next_gap;
         metal_seen <= next_metal_seen;
         near_prev  <= next_near_prev;
         strobe     <= next_strobe;
         ftype      <= next_ftype;
      end
   end

   // Counters: total steps at the start of a fault, per type when it is typed.
   logic [COUNT_W-1:0]       total;
   logic [3:0][COUNT_W-1:0]  tcnt;
   logic [COUNT_W-1:0]       next_total;
   logic [3:0][COUNT_W-1:0]  next_tcnt;
   always_comb begin
      next_total = total;
      next_tcnt  = tcnt;
      if (count_clear) begin
         next_total = COUNT_ZERO;
         next_tcnt  = '0;
      end else begin
         if (fault_event) begin
            next_total = bcd_inc(total);
         end
         if (strobe) begin
            next_tcnt[ftype] = bcd_inc(tcnt[ftype]);
         end
      end
   end

   // Fault relay state machine.
   farc_rstate_t       rstate;
   farc_rstate_t       next_rstate;
   logic [TIMER_W-1:0] pcd;
   logic [TIMER_W-1:0] next_pcd;
   logic               bare;
   logic               next_bare;
   always_comb begin
      next_rstate = rstate;
      next_pcd    = pcd;
      case (rstate)
         FR_IDLE: begin
            if (fault_event) begin
               next_rstate = i_latch_mode ? FR_LATCHED : FR_ACTIVE;
            end
         end
         FR_ACTIVE: begin
            if (!i_defect) begin
               next_pcd    = i_pcd_cycles;
               next_rstate = (i_pcd_cycles == '0) ? FR_IDLE : FR_HOLD;
            end
         end
         FR_HOLD: begin
            if (fault_event) begin
               next_rstate = i_latch_mode ? FR_LATCHED : FR_ACTIVE;
            end else if (pcd <= TIMER_W'(1)) begin
               next_rstate = FR_IDLE;
            end else begin
               next_pcd = pcd - 1'b1;
            end
         end
         FR_LATCHED: begin
            // Resets outside this state are ignored entirely.
            if (reset_req) begin
               next_rstate = FR_IDLE;
            end
         end
         default: next_rstate = FR_IDLE;
      endcase
      // Bare wire holds with the fault relay and drops when it drops.
      next_bare = bare | (i_defect & i_metal)
                | (strobe & (ftype == FT_METAL || ftype == FT_GROSS));
      if (next_rstate == FR_IDLE && !(i_defect & i_metal)) begin
         next_bare = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         total       <= COUNT_ZERO;
         tcnt        <= '0;
         rstate      <= FR_IDLE;
         pcd         <= '0;
         bare        <= 1'b0;
         ext_reset_d <= 1'b0;
      end else begin
         total       <= next_total;
         tcnt        <= next_tcnt;
         rstate      <= next_rstate;
         pcd         <= next_pcd;
         bare        <= next_bare;
         ext_reset_d <= deb[1];
      end
   end

   // Output stage: every pin leaves from a flop.
   logic               fault_act;
   logic               hv_on;
   logic               hv_lamp;
   logic               wd;
   logic [3:0]         relay;
   logic [VOLT_W-1:0]  diff;
   logic [31:0]        lhs;
   logic [31:0]        rhs;
   assign fault_act = (next_rstate != FR_IDLE);
   assign diff = (i_volt_meas > i_volt_setpoint) ? i_volt_meas - i_volt_setpoint
                                                 : i_volt_setpoint - i_volt_meas;
   assign lhs = 32'(diff) * 32'(PCT_SCALE);
   assign rhs = 32'(i_volt_setpoint) * 32'(i_setpoint_percent_window);

   always_comb begin
      // Removal only bites in latch mode, so a stale option cannot block HV.
      hv_on = permit_ok & i_hv_request
            & ~(i_latch_mode & i_remove_hv & (next_rstate == FR_LATCHED));
      hv_lamp = i_volt_meas > HV_LAMP_VOLTS;
      if (i_wd_mode == WD_LIMIT) begin
         wd = (i_volt_meas > i_watchdog_limit_window_hi)
            | (i_volt_meas < i_watchdog_limit_window_lo);
      end else begin
         wd = lhs > rhs;
      end
      wd = wd & o_hv_on;
      for (int k = 0; k < 4; k++) begin
         case (i_relay_func[k])
            RF_HV_ON:    relay[k] = hv_lamp;
            RF_FAULT:    relay[k] = fault_act;
            RF_BARE:     relay[k] = next_bare;
            RF_WATCHDOG: relay[k] = wd;
            default:     relay[k] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_fault_pulse      <= 1'b0;
         o_any_fault        <= 1'b0;
         o_fault_lamp       <= 1'b0;
         o_fault_type       <= FT_PINHOLE;
         o_type_valid       <= 1'b0;
         o_total_count      <= COUNT_ZERO;
         o_type_count       <= '0;
         o_hv_on            <= 1'b0;
         o_hv_lamp          <= 1'b0;
         o_wd_alarm         <= 1'b0;
         o_relay            <= 4'h0;
         o_cfg_allowed      <= 1'b1;
         o_volt_adj_allowed <= 1'b1;
      end else begin
         o_fault_pulse      <= i_defect;
         o_any_fault        <= fault_act;
         o_fault_lamp       <= fault_act;
         o_fault_type       <= next_ftype;
         o_type_valid       <= next_strobe;
         o_total_count      <= next_total;
         o_type_count       <= next_tcnt;
         o_hv_on            <= hv_on;
         o_hv_lamp          <= hv_lamp;
         o_wd_alarm         <= wd;
         o_relay            <= relay;
         o_cfg_allowed      <= ~i_locked;
         o_volt_adj_allowed <= ~(i_locked & (i_lock_level >= LOCK_VOLT));
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_latched_held;
      rstate == FR_LATCHED && !reset_req;
   endsequence
   sequence s_latched_reset;
      rstate == FR_LATCHED ##0 reset_req;
   endsequence

   a_permit_gates_hv: assert property (!permit_ok |=> !o_hv_on)
      else $error("high voltage on without permit");
   a_latch_holds: assert property (s_latched_held |=> rstate == FR_LATCHED && o_any_fault)
      else $error("latched fault dropped without reset");
   a_remove_hv_off: assert property (s_latched_held ##0 i_remove_hv && i_latch_mode |=> !o_hv_on)
      else $error("voltage not removed while latched");
   a_keep_hv_latched: assert property (s_latched_held ##0 !i_remove_hv && permit_ok && i_hv_request
      |=> o_hv_on)
      else $error("voltage dropped while latched without removal");
   a_reset_restores: assert property (s_latched_reset ##0 i_remove_hv && permit_ok && i_hv_request
      && !fault_event |=> rstate == FR_IDLE && o_hv_on && !o_any_fault)
      else $error("reset did not restore voltage");
   a_nolatch_hv_on: assert property (!i_latch_mode && permit_ok && i_hv_request
      && rstate != FR_LATCHED |=> o_hv_on)
      else $error("voltage removed in non-latch mode");
   a_count_once: assert property (defect_d && i_defect && !count_clear |=> $stable(total))
      else $error("fault counted twice");
   // A type strobe in the reset cycle is a legal count step, not a reset effect.
   a_reset_keeps_count: assert property (reset_req && !fault_event && !count_clear && !strobe
      |=> $stable(total) && $stable(tcnt))
      else $error("fault reset changed a count");
   a_count_clear: assert property (count_clear |=> total == COUNT_ZERO && o_total_count == COUNT_ZERO)
      else $error("count reset left a count");
   a_idle_reset_noop: assert property (rstate == FR_IDLE && reset_req && !fault_event
      |=> rstate == FR_IDLE)
      else $error("reset while idle changed relay state");
endmodule

// >>> testbench/farc_contact_model.sv
`timescale 1ns/1ns
// Far-side contacts: the permit jumper or switch and the reset-to-ground switch.
module farc_contact_model (
   input  wire logic i_clk,
   input  wire logic i_permit_close,
   input  wire logic i_reset_close,
   output logic      o_hv_permit_input_n,
   output logic      o_ext_reset_n
);
   logic [3:0] permit_age;
   logic [3:0] reset_age;

   // Open contacts read high through their pull-ups before the first edge.
   initial begin
      o_hv_permit_input_n = 1'b1;
      o_ext_reset_n       = 1'b1;
      permit_age          = 4'h0;
      reset_age           = 4'h0;
   end

   // A closing contact chatters for three cycles before it settles low, so the
   // debounce in the block sees a real mechanical closure every time.
   always @(posedge i_clk) begin
      if (i_permit_close) begin
         permit_age <= (permit_age == 4'hf) ? permit_age : permit_age + 4'h1;
         o_hv_permit_input_n <= (permit_age < 4'h3) ? permit_age[0] : 1'b0;
      end else begin
         permit_age <= 4'h0;
         o_hv_permit_input_n <= 1'b1;
      end
      if (i_reset_close) begin
         reset_age <= (reset_age == 4'hf) ? reset_age : reset_age + 4'h1;
         o_ext_reset_n <= (reset_age < 4'h3) ? reset_age[0] : 1'b0;
      end else begin
         reset_age <= 4'h0;
         o_ext_reset_n <= 1'b1;
      end
   end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
   import farc_pkg::*;
   logic                   i_clk, i_rst_n, i_defect, i_metal, i_latch_mode, i_remove_hv;
   logic                   i_hv_request, i_panel_reset, i_remote_reset, i_count_reset;
   logic                   i_locked, permit_close, reset_close;
   wire logic              hv_permit_n, ext_reset_n;
   logic [TIMER_W-1:0]     i_gross_cycles, i_long_cycles, i_spacing_cycles, i_pcd_cycles;
   logic [1:0]             i_lock_level;
   logic [VOLT_W-1:0]      i_volt_meas, i_volt_setpoint, wd_hi, wd_lo;
   logic [6:0]             pct_window;
   farc_wdmode_t           i_wd_mode;
   farc_rfunc_t [3:0]      i_relay_func;
   logic                   o_fault_pulse, o_any_fault, o_fault_lamp, o_type_valid, o_hv_on;
   logic                   o_hv_lamp, o_wd_alarm, o_cfg_allowed, o_volt_adj_allowed;
   farc_ftype_t            o_fault_type, last_type;
   logic [COUNT_W-1:0]     o_total_count;
   logic [3:0][COUNT_W-1:0] o_type_count;
   logic [3:0]             o_relay;
   int                     bad_count, compares, exp_total, n;

   farc_top #(.DEBOUNCE(4)) u_farc_top (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_defect(i_defect), .i_metal(i_metal),
      .i_gross_cycles(i_gross_cycles), .i_long_cycles(i_long_cycles),
      .i_spacing_cycles(i_spacing_cycles), .i_pcd_cycles(i_pcd_cycles),
      .i_latch_mode(i_latch_mode), .i_remove_hv(i_remove_hv), .i_hv_request(i_hv_request),
      .i_hv_permit_input_n(hv_permit_n), .i_ext_reset_n(ext_reset_n),
      .i_panel_reset(i_panel_reset), .i_remote_reset(i_remote_reset),
      .i_count_reset(i_count_reset), .i_locked(i_locked), .i_lock_level(i_lock_level),
      .i_volt_meas(i_volt_meas), .i_volt_setpoint(i_volt_setpoint), .i_wd_mode(i_wd_mode),
      .i_watchdog_limit_window_hi(wd_hi), .i_watchdog_limit_window_lo(wd_lo),
      .i_setpoint_percent_window(pct_window), .i_relay_func(i_relay_func),
      .o_fault_pulse(o_fault_pulse), .o_any_fault(o_any_fault), .o_fault_lamp(o_fault_lamp),
      .o_fault_type(o_fault_type), .o_type_valid(o_type_valid),
      .o_total_count(o_total_count), .o_type_count(o_type_count), .o_hv_on(o_hv_on),
      .o_hv_lamp(o_hv_lamp), .o_wd_alarm(o_wd_alarm), .o_relay(o_relay),
      .o_cfg_allowed(o_cfg_allowed), .o_volt_adj_allowed(o_volt_adj_allowed)
   );

   farc_contact_model u_farc_contact_model (
      .i_clk(i_clk), .i_permit_close(permit_close), .i_reset_close(reset_close),
      .o_hv_permit_input_n(hv_permit_n), .o_ext_reset_n(ext_reset_n)
   );

   // Clock at 20 MHz.
   always #25 i_clk = ~i_clk;

   // The type strobe lasts one cycle, so it is caught mid-cycle and kept.
   always @(negedge i_clk) begin
      if (o_type_valid === 1'b1) last_type <= o_fault_type;
   end

   task automatic cyc(input int k);
      repeat (k) @(negedge i_clk);
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [11:0] bcd(input int v);
      return {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
   endfunction

   // One defect passing the electrode; the counter must step once however long it stays.
   task automatic fault(input logic metal, input int len, input int gap);
      i_defect = 1'b1;
      i_metal = metal;
      exp_total++;
      cyc(2);
      chk(o_fault_pulse, 1'b1);
      chk(o_fault_lamp, 1'b1);
      chk(o_any_fault, 1'b1);
      chk(o_relay[1], 1'b1);
      cyc(len - 2);
      chk(o_total_count, bcd(exp_total));
      chk(o_relay[2], metal);
      i_defect = 1'b0;
      i_metal = 1'b0;
      cyc(gap);
   endtask

   task automatic volt(input farc_wdmode_t m, input logic [15:0] v, input logic wd,
                       input logic lamp);
      i_wd_mode = m;
      i_volt_meas = v;
      cyc(3);
      chk(o_wd_alarm, wd);
      chk(o_relay[3], wd);
      chk(o_hv_lamp, lamp);
      chk(o_relay[0], lamp);
   endtask

   task automatic pulse_remote();
      i_remote_reset = 1'b1;
      cyc(1);
      i_remote_reset = 1'b0;
      cyc(2);
   endtask

   task automatic pulse_panel();
      i_panel_reset = 1'b1;
      cyc(1);
      i_panel_reset = 1'b0;
      cyc(2);
   endtask

   task automatic pulse_count();
      i_count_reset = 1'b1;
      cyc(1);
      i_count_reset = 1'b0;
      cyc(2);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the few hundred cycles the tests need.
   initial begin
      #(50 * 4000);
      bad_count++;
      finish_test();
   end

   // Main sequence: reset, permit, voltage checks, fault typing, latch and counts.
   initial begin
      {i_clk, i_rst_n, i_defect, i_metal, i_latch_mode, i_remove_hv} = 6'h00;
      {i_panel_reset, i_remote_reset, i_count_reset, i_locked} = 4'h0;
      {permit_close, reset_close, bad_count, compares, exp_total} = '0;
      i_hv_request = 1'b1;
      i_gross_cycles = 24'h000014;
      i_long_cycles = 24'h00000a;
      i_spacing_cycles = 24'h000004;
      i_pcd_cycles = 24'h000000;
      i_lock_level = 2'h0;
      {i_volt_meas, i_volt_setpoint, wd_hi, wd_lo} = {16'h0fa0, 16'h0fa0, 16'h1388, 16'h0bb8};
      pct_window = 7'h0a;
      i_wd_mode = WD_LIMIT;
      i_relay_func[0] = RF_HV_ON;
      i_relay_func[1] = RF_FAULT;
      i_relay_func[2] = RF_BARE;
      i_relay_func[3] = RF_WATCHDOG;
      cyc(6);
      chk({o_any_fault, o_hv_on, o_cfg_allowed, o_volt_adj_allowed}, 4'h3);
      chk(o_total_count, 12'h000);
      i_rst_n = 1'b1;
      cyc(12);
      chk(o_hv_on, 1'b0);
      permit_close = 1'b1;
      n = 0;
      while (o_hv_on !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk(n > 5 && n < 40, 1'b1);
      volt(WD_LIMIT, 16'h01f4, 1'b1, 1'b0);
      volt(WD_LIMIT, 16'h01f5, 1'b1, 1'b1);
      volt(WD_LIMIT, 16'h0fa0, 1'b0, 1'b1);
      volt(WD_LIMIT, 16'h1770, 1'b1, 1'b1);
      volt(WD_PERCENT, 16'h10cc, 1'b0, 1'b1);
      volt(WD_PERCENT, 16'h1194, 1'b1, 1'b1);
      volt(WD_PERCENT, 16'h0dac, 1'b1, 1'b1);
      volt(WD_LIMIT, 16'h0fa0, 1'b0, 1'b1);
      i_locked = 1'b1;
      i_lock_level = 2'h1;
      cyc(2);
      chk({o_cfg_allowed, o_volt_adj_allowed}, 2'h0);
      i_lock_level = 2'h0;
      cyc(2);
      chk({o_cfg_allowed, o_volt_adj_allowed}, 2'h1);
      i_locked = 1'b0;
      fault(1'b0, 3, 8);
      chk(last_type, FT_PINHOLE);
      chk(o_any_fault, 1'b0);
      fault(1'b1, 3, 8);
      chk(last_type, FT_METAL);
      fault(1'b1, 25, 8);
      chk(last_type, FT_GROSS);
      fault(1'b0, 12, 8);
      chk(last_type, FT_MULTI);
      fault(1'b0, 2, 1);
      fault(1'b0, 2, 8);
      chk(last_type, FT_MULTI);
      // Non-latch with an extension; voltage removal must not bite here.
      i_pcd_cycles = 24'h000006;
      i_remove_hv = 1'b1;
      fault(1'b0, 3, 3);
      chk(o_any_fault, 1'b1);
      chk(o_hv_on, 1'b1);
      cyc(12);
      chk(o_any_fault, 1'b0);
      i_pcd_cycles = 24'h000000;
      i_remove_hv = 1'b0;
      i_latch_mode = 1'b1;
      fault(1'b0, 3, 8);
      chk({o_any_fault, o_relay[1], o_hv_on}, 3'h7);
      pulse_remote();
      chk({o_any_fault, o_relay[1]}, 2'h0);
      pulse_remote();
      chk({o_any_fault, o_hv_on}, 2'h1);
      i_remove_hv = 1'b1;
      fault(1'b0, 3, 8);
      chk({o_any_fault, o_hv_on}, 2'h2);
      i_locked = 1'b1;
      i_lock_level = 2'h3;
      pulse_panel();
      chk(o_any_fault, 1'b1);
      i_locked = 1'b0;
      pulse_panel();
      chk({o_any_fault, o_hv_on}, 2'h1);
      fault(1'b0, 3, 8);
      chk(o_hv_on, 1'b0);
      // Remap relay 0 to the fault function while latched, then put it back.
      i_relay_func[0] = RF_FAULT;
      cyc(2);
      chk(o_relay[0], 1'b1);
      i_relay_func[0] = RF_HV_ON;
      reset_close = 1'b1;
      n = 0;
      while (o_any_fault !== 1'b0 && n < 30) begin
         cyc(1);
         n++;
      end
      reset_close = 1'b0;
      cyc(2);
      chk({o_any_fault, o_hv_on}, 2'h1);
      chk(o_total_count, 12'h010);
      chk(o_type_count[FT_PINHOLE], 12'h006);
      chk(o_type_count[FT_METAL], 12'h001);
      chk(o_type_count[FT_MULTI], 12'h002);
      chk(o_type_count[FT_GROSS], 12'h001);
      i_locked = 1'b1;
      i_lock_level = 2'h2;
      pulse_count();
      chk(o_total_count, 12'h010);
      i_locked = 1'b0;
      pulse_count();
      chk(o_total_count, 12'h000);
      for (int t = 0; t < 4; t++) chk(o_type_count[t], 12'h000);
      permit_close = 1'b0;
      cyc(12);
      chk(o_hv_on, 1'b0);
      finish_test();
   end
endmodule
